// >>> hw/dst_engine.sv
// sector write, address read, track read and track write engine
`timescale 1ns/1ps
module dst_engine
   import dst_pkg::*;
(
   // clock and reset
   input  wire logic          clock_i,
   input  wire logic          reset_n_i,
   // command and target
   input  wire logic          cmd_valid_i,
   input  wire dst_pkg::dst_cmd_t cmd_i,
   input  wire logic          density_select_i,
   input  wire logic [7:0]    track_i,
   input  wire logic [7:0]    sector_i,
   input  wire logic          side_i,
   // host byte exchange
   input  wire logic          host_wr_i,
   input  wire logic          host_rd_i,
   input  wire logic [7:0]    host_data_i,
   output logic [7:0]         host_data_o,
   output logic               byte_request_o,
   // status
   output logic               busy_o,
   output logic               completion_irq_o,
   output logic               lost_data_o,
   output logic               crc_error_o,
   output logic [7:0]         sector_reg_o,
   // drive side
   input  wire logic          index_i,
   input  wire dst_pkg::dst_rd_t rd_i,
   output logic               head_load_out_o,
   output logic               write_gate_out_o,
   output logic               read_gate_o,
   output dst_pkg::dst_wr_t   wr_o
);
   import dst_pkg::*;

   // ----------------------------------------
   // state
   // ----------------------------------------
   dst_state_t r_ff, nxt_r;
   logic       tick, idx, fm, idok, idmatch;
   logic [15:0] ncrc;
   logic [7:0]  b;
   dst_enc_t    e;

   // outputs straight from the state flops
   assign host_data_o      = r_ff.dout;
   assign byte_request_o   = r_ff.req;
   assign busy_o           = r_ff.busy;
   assign completion_irq_o = r_ff.irq;
   assign lost_data_o      = r_ff.lost;
   assign crc_error_o      = r_ff.crce;
   assign sector_reg_o     = r_ff.secr;
   assign head_load_out_o  = r_ff.head_load_out;
   assign write_gate_out_o = r_ff.wg;
   assign read_gate_o      = r_ff.rg;
   assign wr_o             = r_ff.wr;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      nxt_r = r_ff;
      b = 8'h00;
      e = dst_encode(8'h00, 1'b1);
      // index and density pins pass two flops before use
      nxt_r.isy = {r_ff.isy[0], index_i};
      nxt_r.dsy = {r_ff.dsy[0], density_select_i};
      nxt_r.idxd = r_ff.isy[1];
      idx = r_ff.isy[1] & ~r_ff.idxd;
      fm = r_ff.dsy[1];
      nxt_r.wr.stb = 1'b0;
      ncrc = dst_crc8(r_ff.crc, rd_i.data);
      idok = (ncrc == 16'h0000);
      idmatch = (r_ff.id[31:24] == track_i) && (r_ff.id[15:8] == sector_i)
              && (r_ff.id[16] == side_i);
      // host read clears first so a new request in this cycle wins
      if (host_rd_i) begin
         nxt_r.req = 1'b0;
      end
      // byte slot timer, free running while busy
      tick = 1'b0;
      if (!r_ff.busy) begin
         nxt_r.bcnt = '0;
      end else if (r_ff.bcnt == '0) begin
         tick = 1'b1;
         nxt_r.bcnt = fm ? 11'(FM_BYTE_CYC - 1) : 11'(MFM_BYTE_CYC - 1);
      end else begin
         nxt_r.bcnt = r_ff.bcnt - 11'd1;
      end
      if (r_ff.iact) begin
         if (r_ff.icnt == 9'(IRQ_CYC - 1)) begin
            nxt_r.iact = 1'b0;
            nxt_r.irq = 1'b1;
         end else begin
            nxt_r.icnt = r_ff.icnt + 9'd1;
         end
      end
      case (r_ff.st)
         S_IDLE: begin
            if (cmd_valid_i) begin
               nxt_r.cmd = cmd_i;
               nxt_r.busy = 1'b1;
               nxt_r.head_load_out = 1'b1;
               nxt_r.irq = 1'b0;
               nxt_r.lost = 1'b0;
               nxt_r.crce = 1'b0;
               nxt_r.ld = 1'b0;
               nxt_r.req = 1'b0;
               nxt_r.cnt = '0;
               case (cmd_i.op)
                  OP_RTRK: nxt_r.st = S_RTW;
                  OP_WTRK: begin
                     nxt_r.st = S_WTW;
                     nxt_r.req = 1'b1;
                  end
                  default: begin
                     nxt_r.st = S_SRCH;
                     nxt_r.rg = 1'b1;
                  end
               endcase
            end
         end
         S_SRCH: begin
            if (rd_i.valid && rd_i.mark && rd_i.data == ID_MARK) begin
               nxt_r.st = S_ID;
               nxt_r.cnt = '0;
               nxt_r.crc = dst_crc8(CRC_PRE, rd_i.data);
            end
         end
         S_ID: begin
            if (rd_i.valid) begin
               // crc over the field and its own crc leaves zero when good
               nxt_r.crc = ncrc;
               nxt_r.cnt = r_ff.cnt + 11'd1;
               if (r_ff.cnt < 11'd4) begin
                  nxt_r.id = {r_ff.id[23:0], rd_i.data};
               end
               if (r_ff.cmd.op == OP_RADDR) begin
                  // each id byte through the holding register
                  nxt_r.dout = rd_i.data;
                  nxt_r.req = 1'b1;
                  if (r_ff.req) begin
                     nxt_r.lost = 1'b1;
                  end
               end
               if (r_ff.cnt == 11'(ID_LAST)) begin
                  if (r_ff.cmd.op == OP_RADDR) begin
                     nxt_r.crce = ~idok;
                     nxt_r.secr = r_ff.id[31:24];
                     nxt_r.irq = 1'b1;
                     nxt_r.busy = 1'b0;
                     nxt_r.rg = 1'b0;
                     nxt_r.st = S_IDLE;
                  end else if (idok && idmatch) begin
                     nxt_r.req = 1'b1;
                     nxt_r.rg = 1'b0;
                     nxt_r.cnt = '0;
                     nxt_r.st = S_GAP;
                  end else begin
                     nxt_r.st = S_SRCH;
                  end
               end
            end
         end
         S_GAP: begin
            if (tick) begin
               nxt_r.cnt = r_ff.cnt + 11'd1;
               if (r_ff.cnt == (fm ? 11'(GAP_FM - 1) : 11'(GAP_MFM - 1))) begin
                  nxt_r.cnt = '0;
                  // gate only if the host has loaded a byte
                  if (!r_ff.ld) begin
                     nxt_r.lost = 1'b1;
                     nxt_r.busy = 1'b0;
                     nxt_r.irq = 1'b1;
                     nxt_r.req = 1'b0;
                     nxt_r.st = S_IDLE;
                  end else begin
                     nxt_r.wg = 1'b1;
                     nxt_r.st = S_SYNC;
                  end
               end
            end
         end
         S_SYNC: begin
            if (tick) begin
               // zero bytes ahead of the mark
               nxt_r.wr = '{ZERO_BYTE, fm ? CLK_NORM : 8'h00, 1'b1};
               nxt_r.cnt = r_ff.cnt + 11'd1;
               if (r_ff.cnt == (fm ? 11'(SYNC_FM - 1) : 11'(SYNC_MFM - 1))) begin
                  nxt_r.st = S_DMK;
               end
            end
         end
         S_DMK: begin
            if (tick) begin
               e = dst_encode(r_ff.cmd.del ? DEL_MARK : DATA_MARK, fm);
               nxt_r.wr = '{e.d, e.c, 1'b1};
               nxt_r.crc = dst_crc8(CRC_PRE, e.d);
               nxt_r.cnt = '0;
               nxt_r.st = S_DATA;
            end
         end
         S_DATA: begin
            if (tick) begin
               // missed byte becomes zero, command goes on
               b = r_ff.ld ? r_ff.hold : ZERO_BYTE;
               if (!r_ff.ld) begin
                  nxt_r.lost = 1'b1;
               end
               nxt_r.ld = 1'b0;
               nxt_r.wr = '{b, fm ? CLK_NORM : 8'h00, 1'b1};
               nxt_r.crc = dst_crc8(r_ff.crc, b);
               nxt_r.cnt = r_ff.cnt + 11'd1;
               // field length from the id length code
               if (r_ff.cnt == (11'(SECT_BASE) << r_ff.id[1:0]) - 11'd1) begin
                  nxt_r.st = S_CRC1;
               end else begin
                  nxt_r.req = 1'b1;
               end
            end
         end
         S_CRC1: begin
            if (tick) begin
               nxt_r.wr = '{r_ff.crc[15:8], fm ? CLK_NORM : 8'h00, 1'b1};
               nxt_r.st = S_CRC2;
            end
         end
         S_CRC2: begin
            if (tick) begin
               nxt_r.wr = '{r_ff.crc[7:0], fm ? CLK_NORM : 8'h00, 1'b1};
               nxt_r.st = S_TAIL;
            end
         end
         S_TAIL: begin
            if (tick) begin
               // all-ones byte; delay runs from crc end
               nxt_r.wr = '{TAIL_BYTE, fm ? CLK_NORM : 8'h00, 1'b1};
               nxt_r.iact = 1'b1;
               nxt_r.icnt = '0;
               nxt_r.st = S_END;
            end
         end
         S_END: begin
            if (tick) begin
               // gate drops after the tail byte
               nxt_r.wg = 1'b0;
               nxt_r.busy = 1'b0;
               nxt_r.st = S_IDLE;
            end
         end
         S_RTW: begin
            if (idx) begin
               nxt_r.st = S_RT;
            end
         end
         S_RT: begin
            // every byte until the next index edge
            if (idx) begin
               nxt_r.irq = 1'b1;
               nxt_r.busy = 1'b0;
               nxt_r.st = S_IDLE;
            end else begin
               if (rd_i.valid) begin
                  nxt_r.dout = rd_i.data;
                  nxt_r.req = 1'b1;
                  if (r_ff.req) begin
                     nxt_r.lost = 1'b1;
                  end
               end
               // separator realigns on marks; a late mark is lost data
               if (rd_i.miss) begin
                  nxt_r.lost = 1'b1;
               end
            end
         end
         S_WTW: begin
            if (idx) begin
               // no first byte by the index ends the command
               if (r_ff.ld) begin
                  nxt_r.wg = 1'b1;
                  nxt_r.ph = 1'b0;
                  nxt_r.st = S_WT;
                  nxt_r.bcnt = '0;
               end else begin
                  nxt_r.lost = 1'b1;
                  nxt_r.irq = 1'b1;
                  nxt_r.busy = 1'b0;
                  nxt_r.req = 1'b0;
                  nxt_r.st = S_IDLE;
               end
            end
         end
         S_WT: begin
            if (idx) begin
               // stop at the next index edge
               nxt_r.wg = 1'b0;
               nxt_r.irq = 1'b1;
               nxt_r.busy = 1'b0;
               nxt_r.req = 1'b0;
               nxt_r.st = S_IDLE;
            end else if (tick) begin
               if (r_ff.ph) begin
                  nxt_r.wr = '{r_ff.crc[7:0], fm ? CLK_NORM : 8'h00, 1'b1};
                  nxt_r.ph = 1'b0;
               end else begin
                  b = r_ff.ld ? r_ff.hold : ZERO_BYTE;
                  nxt_r.ld = 1'b0;
                  nxt_r.req = 1'b1;
                  e = dst_encode(b, fm);
                  if (e.crc) begin
                     nxt_r.wr = '{r_ff.crc[15:8], fm ? CLK_NORM : 8'h00, 1'b1};
                     nxt_r.ph = 1'b1;
                  end else begin
                     nxt_r.wr = '{e.d, e.c, 1'b1};
                     // preset as the byte enters the shifter
                     nxt_r.crc = dst_crc8(e.pre ? CRC_PRE : r_ff.crc, e.d);
                  end
               end
            end
         end
         default: nxt_r.st = S_IDLE;
      endcase
      // a host write services the pending request
      if (host_wr_i) begin
         nxt_r.hold = host_data_i;
         nxt_r.ld = 1'b1;
         nxt_r.req = 1'b0;
      end
   end

   // state register
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         r_ff <= '0;
      end else begin
         r_ff <= nxt_r;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   localparam int A_LO = IRQ_CYC;
   localparam int A_HI = IRQ_MAX_NS / CLK_NS;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!reset_n_i);

   property p_start;
      cmd_valid_i && !busy_o |=> head_load_out_o && busy_o;
   endproperty
   a_start: assert property (p_start) else $error("no head load at start");
   property p_req;
      (r_ff.st != S_GAP) ##1 (r_ff.st == S_GAP) |-> byte_request_o || r_ff.ld;
   endproperty
   a_req: assert property (p_req) else $error("no request on match");
   property p_gap;
      r_ff.st == S_GAP && tick && !r_ff.ld && !host_wr_i
         && r_ff.cnt == (fm ? 11'(GAP_FM - 1) : 11'(GAP_MFM - 1))
         |=> lost_data_o && !write_gate_out_o && !busy_o;
   endproperty
   a_gap: assert property (p_gap) else $error("unserviced gap not ended");
   property p_sync;
      r_ff.st == S_SYNC && tick |=> wr_o.stb && wr_o.data == ZERO_BYTE && write_gate_out_o;
   endproperty
   a_sync: assert property (p_sync) else $error("sync byte not zero");
   property p_mark;
      r_ff.st == S_DMK && tick |=> wr_o.data == (r_ff.cmd.del ? DEL_MARK : DATA_MARK);
   endproperty
   a_mark: assert property (p_mark) else $error("wrong data mark");
   property p_fill;
      r_ff.st == S_DATA && tick && !r_ff.ld |=> wr_o.data == ZERO_BYTE && lost_data_o;
   endproperty
   a_fill: assert property (p_fill) else $error("missed byte not zero");
   property p_tail;
      r_ff.st == S_TAIL && tick |=> wr_o.data == TAIL_BYTE && write_gate_out_o;
   endproperty
   a_tail: assert property (p_tail) else $error("tail byte wrong");
   property p_irq;
      r_ff.st == S_TAIL && tick |-> ##[A_LO:A_HI] completion_irq_o;
   endproperty
   a_irq: assert property (p_irq) else $error("late sector interrupt");
   property p_raddr;
      r_ff.st == S_ID && r_ff.cmd.op == OP_RADDR && rd_i.valid && r_ff.cnt == 11'(ID_LAST)
         |=> !busy_o && completion_irq_o && sector_reg_o == $past(r_ff.id[31:24]);
   endproperty
   a_raddr: assert property (p_raddr) else $error("bad address end");
   property p_rgate;
      r_ff.st == S_RT |-> !read_gate_o;
   endproperty
   a_rgate: assert property (p_rgate) else $error("read gate in track read");
   property p_wtlost;
      r_ff.st == S_WTW && idx && !r_ff.ld |=> lost_data_o && completion_irq_o && !busy_o;
   endproperty
   a_wtlost: assert property (p_wtlost) else $error("empty track write kept on");
   c_sector: cover property (r_ff.st == S_TAIL && tick);
   c_track: cover property (r_ff.st == S_WT && idx);
   c_addr: cover property (r_ff.st == S_ID ##1 r_ff.st == S_IDLE);
endmodule : dst_engine

// >>> hw/dst_pkg.sv
// shared constants, types and helpers of the sector and track engine
package dst_pkg;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_NS       = 20;
   localparam int FM_BYTE_NS   = 32000;
   localparam int MFM_BYTE_NS  = 16000;
   localparam int FM_BYTE_CYC  = FM_BYTE_NS / CLK_NS;
   localparam int MFM_BYTE_CYC = MFM_BYTE_NS / CLK_NS;
   localparam int IRQ_MIN_NS   = 8000;
   localparam int IRQ_MAX_NS   = 12000;
   localparam int IRQ_CYC      = (IRQ_MIN_NS + CLK_NS - 1) / CLK_NS;
   // ----------------------------------------
   // byte counts and codes
   // ----------------------------------------
   localparam int GAP_FM    = 11;
   localparam int GAP_MFM   = 22;
   localparam int SYNC_FM   = 6;
   localparam int SYNC_MFM  = 12;
   localparam int ID_LAST   = 5;
   localparam int SECT_BASE = 128;
   localparam logic [7:0]  ZERO_BYTE = 8'h00;
   localparam logic [7:0]  TAIL_BYTE = 8'hff;
   localparam logic [7:0]  ID_MARK   = 8'hfe;
   localparam logic [7:0]  DATA_MARK = 8'hfb;
   localparam logic [7:0]  DEL_MARK  = 8'hf8;
   localparam logic [7:0]  IDX_MARK  = 8'hfc;
   localparam logic [7:0]  CRC_CODE  = 8'hf7;
   localparam logic [7:0]  MFM_F5    = 8'hf5;
   localparam logic [7:0]  MFM_F6    = 8'hf6;
   localparam logic [7:0]  MFM_A1    = 8'ha1;
   localparam logic [7:0]  MFM_C2    = 8'hc2;
   localparam logic [7:0]  MISS_A1   = 8'h10;
   localparam logic [7:0]  MISS_C2   = 8'h08;
   localparam logic [7:0]  CLK_NORM  = 8'hff;
   localparam logic [7:0]  CLK_MARK  = 8'hc7;
   localparam logic [7:0]  CLK_IDX   = 8'hd7;
   localparam logic [15:0] CRC_PRE   = 16'hffff;
   localparam logic [15:0] CRC_POLY  = 16'h1021;
   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0] {OP_WSEC, OP_RADDR, OP_RTRK, OP_WTRK} dst_op_t;
   typedef struct packed {dst_op_t op; logic del;} dst_cmd_t;
   typedef struct packed {logic [7:0] data; logic valid; logic mark; logic miss;} dst_rd_t;
   typedef struct packed {logic [7:0] data; logic [7:0] clk; logic stb;} dst_wr_t;
   typedef struct packed {logic [7:0] d; logic [7:0] c; logic pre; logic crc;} dst_enc_t;
   typedef enum logic [3:0] {
      S_IDLE = 4'h0, S_SRCH = 4'h1, S_ID = 4'h3, S_GAP = 4'h2, S_SYNC = 4'h6,
      S_DMK = 4'h7, S_DATA = 4'h5, S_CRC1 = 4'h4, S_CRC2 = 4'hc, S_TAIL = 4'hd,
      S_END = 4'hf, S_RTW = 4'he, S_RT = 4'ha, S_WTW = 4'hb, S_WT = 4'h9
   } dst_st_t;
   typedef struct packed {
      dst_st_t    st;
      logic       busy, head_load_out, wg, rg, req, irq, lost, crce, ld, iact, ph;
      logic [7:0] dout, hold, secr;
      dst_wr_t    wr;
      dst_cmd_t   cmd;
      logic [10:0] cnt, bcnt;
      logic [8:0] icnt;
      logic [15:0] crc;
      logic [31:0] id;
      logic [1:0] isy, dsy;
      logic       idxd;
   } dst_state_t;

   // crc-ccitt over one byte, msb first
   function automatic logic [15:0] dst_crc8(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] x;
      x = c;
      for (int i = 7; i >= 0; i--) begin
         x = (x[15] ^ d[i]) ? ((x << 1) ^ CRC_POLY) : (x << 1);
      end
      return x;
   endfunction : dst_crc8

   // data, clock pattern (fm) or omitted-clock mask (mfm) for one written byte
   function automatic dst_enc_t dst_encode(input logic [7:0] b, input logic fm);
      dst_enc_t e;
      e = '{d: b, c: (fm ? CLK_NORM : 8'h00), pre: 1'b0, crc: (b == CRC_CODE)};
      if (fm) begin
         if (b inside {[DEL_MARK:DATA_MARK], ID_MARK}) begin
            e.c = CLK_MARK;
            e.pre = 1'b1;
         end else if (b == IDX_MARK) begin
            e.c = CLK_IDX;
         end
      end else if (b == MFM_F5) begin
         e = '{d: MFM_A1, c: MISS_A1, pre: 1'b1, crc: 1'b0};
      end else if (b == MFM_F6) begin
         e = '{d: MFM_C2, c: MISS_C2, pre: 1'b0, crc: 1'b0};
      end
      return e;
   endfunction : dst_encode
endpackage : dst_pkg

// >>> verif/dst_drive.sv
// drive model: index pulses and address fields on the read stream
`timescale 1ns/1ps
module dst_drive (
   // clock
   input  wire logic        clock_i,
   // drive pins
   output logic             index_o,
   output dst_pkg::dst_rd_t rd_o
);
   import dst_pkg::*;
   // idle pins at time zero
   initial begin
      index_o = 1'b0;
      rd_o    = '{data: 8'h5a, valid: 1'b0, mark: 1'b0, miss: 1'b0};
   end
   // index pulse, wide enough for the two-flop sync
   task automatic pulse_index();
      @(posedge clock_i);
      index_o <= 1'b1;
      repeat (4) @(posedge clock_i);
      index_o <= 1'b0;
   endtask : pulse_index
   // one byte strobe; idle data is inverted so a stale byte never matches
   task automatic put(input logic [7:0] b, input logic m);
      @(posedge clock_i);
      rd_o <= '{data: b, valid: 1'b1, mark: m, miss: 1'b0};
      @(posedge clock_i);
      rd_o <= '{data: ~b, valid: 1'b0, mark: 1'b0, miss: 1'b0};
      repeat (40) @(posedge clock_i);
   endtask : put
   // address field: mark, four id bytes, crc high then low
   task automatic send_id(input logic [7:0] f [4], input logic [15:0] crc);
      put(ID_MARK, 1'b1);
      foreach (f[i]) put(f[i], 1'b0);
      put(crc[15:8], 1'b0);
      put(crc[7:0], 1'b0);
   endtask : send_id
   // one pulse of the separator's missing-mark flag
   task automatic miss();
      @(posedge clock_i);
      rd_o.miss <= 1'b1;
      @(posedge clock_i);
      rd_o.miss <= 1'b0;
   endtask : miss
endmodule : dst_drive

// >>> verif/tb_dst_engine.sv
// self-checking bench of the sector and track engine
`timescale 1ns/1ps
module tb_dst_engine;
   import dst_pkg::*;
   logic        clock_i, reset_n_i, cmd_valid_i, density_select_i, side_i, index_i;
   logic        host_wr_i, host_rd_i, byte_request_o, busy_o, completion_irq_o;
   logic        lost_data_o, crc_error_o, head_load_out_o, write_gate_out_o, read_gate_o;
   logic [7:0]  track_i, sector_i, host_data_i, host_data_o, sector_reg_o, r, b, q [4];
   logic [7:0]  f [4];
   logic [15:0] c, w, cw;
   logic [15:0] exq [$];
   dst_cmd_t    cmd_i;
   dst_rd_t     rd_i;
   dst_wr_t     wr_o;
   int          fail_count, n_tests;
   dst_engine dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .cmd_valid_i(cmd_valid_i),
      .cmd_i(cmd_i), .density_select_i(density_select_i), .track_i(track_i),
      .sector_i(sector_i), .side_i(side_i), .host_wr_i(host_wr_i), .host_rd_i(host_rd_i),
      .host_data_i(host_data_i), .host_data_o(host_data_o), .byte_request_o(byte_request_o),
      .busy_o(busy_o), .completion_irq_o(completion_irq_o), .lost_data_o(lost_data_o),
      .crc_error_o(crc_error_o), .sector_reg_o(sector_reg_o), .index_i(index_i),
      .rd_i(rd_i), .head_load_out_o(head_load_out_o), .write_gate_out_o(write_gate_out_o),
      .read_gate_o(read_gate_o), .wr_o(wr_o));
   dst_drive drv (.clock_i(clock_i), .index_o(index_i), .rd_o(rd_i));
   // 50 mhz clock
   initial begin
      clock_i = 1'b0;
      forever #10 clock_i = ~clock_i;
   end
   task automatic chk(input logic [15:0] g, input logic [15:0] x);
      n_tests++;
      if (g !== x) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, g, x);
      end
   endtask : chk
   function automatic logic sig(input int w);
      case (w)
         0: return byte_request_o;
         1: return wr_o.stb;
         2: return completion_irq_o;
         default: return ~busy_o;
      endcase
   endfunction : sig
   // bounded wait for a design flag
   task automatic wait_hi(input int w, input int lim);
      int k;
      k = 0;
      while (sig(w) !== 1'b1 && k < lim) begin
         @(posedge clock_i);
         #1;
         k++;
      end
      if (k >= lim) begin
         fail_count++;
         $display("mismatch at %0t: wait %0d expired", $time, w);
      end
   endtask : wait_hi
   // lfsr bytes, kept below f5 so they never look like marks
   function automatic logic [7:0] rnd();
      r = {r[6:0], r[7] ^ r[5] ^ r[4] ^ r[3]};
      return r & 8'h7f;
   endfunction : rnd
   function automatic logic [15:0] crc_b(input logic [15:0] x, input logic [7:0] d);
      for (int i = 7; i >= 0; i--)
         x = (x[15] ^ d[i]) ? ({x[14:0], 1'b0} ^ 16'h1021) : {x[14:0], 1'b0};
      return x;
   endfunction : crc_b
   // written data and clock (fm) or omitted-clock mask (mfm) of one host byte
   function automatic logic [15:0] wexp(input logic [7:0] x, input logic m);
      if (m) begin
         return {x, (x inside {[8'hf8:8'hfb], 8'hfe} ? 8'hc7 : (x == 8'hfc ? 8'hd7 : 8'hff))};
      end
      return x == 8'hf5 ? 16'ha110 : (x == 8'hf6 ? 16'hc208 : {x, 8'h00});
   endfunction : wexp
   task automatic go(input dst_op_t op, input logic dl = 1'b0);
      @(posedge clock_i);
      cmd_i       <= '{op: op, del: dl};
      cmd_valid_i <= 1'b1;
      @(posedge clock_i);
      cmd_valid_i <= 1'b0;
      #1;
      chk(busy_o & head_load_out_o, 1'b1);
      chk(read_gate_o, op inside {OP_WSEC, OP_RADDR});
   endtask : go
   // one host byte write or read acknowledge
   task automatic host(input logic wr, input logic [7:0] d);
      @(posedge clock_i);
      host_wr_i   <= wr;
      host_rd_i   <= ~wr;
      host_data_i <= d;
      @(posedge clock_i);
      {host_wr_i, host_rd_i} <= 2'b00;
      #1;
   endtask : host
   task automatic stop_test();
      $display("tests %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : stop_test
   // watchdog
   initial begin
      repeat (90000) @(posedge clock_i);
      fail_count++;
      stop_test();
   end
   // main sequence
   initial begin
      {reset_n_i, cmd_valid_i, density_select_i, side_i, host_wr_i, host_rd_i} = '0;
      {track_i, sector_i, host_data_i} = '0;
      cmd_i = '0;
      r = 8'h3d;
      repeat (2) @(posedge clock_i);
      reset_n_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      f = '{rnd(), 8'h00, rnd(), 8'h01};
      c = crc_b(16'hffff, ID_MARK);
      foreach (f[i]) c = crc_b(c, f[i]);
      for (int bad = 0; bad < 2; bad++) begin
         go(OP_RADDR);
         fork
            drv.send_id(f, c ^ 16'(bad));
            for (int i = 0; i < 6; i++) begin
               wait_hi(0, 200);
               chk(host_data_o, i < 4 ? f[i] : (i == 4 ? c[15:8] : c[7:0] ^ 8'(bad)));
               host(1'b0, 8'h00);
            end
         join
         chk(crc_error_o, 8'(bad));
         chk({busy_o, completion_irq_o, sector_reg_o}, {2'b01, f[0]});
      end
      {track_i, sector_i, side_i} <= {f[0], f[2], 1'b0};
      go(OP_WSEC);
      drv.send_id(f, c);
      chk(byte_request_o, 1'b1);
      wait_hi(3, 20000);
      chk({lost_data_o, completion_irq_o, write_gate_out_o}, 3'b110);
      // loaded sector: gate, zeros, deleted mark, first byte, then a missed byte
      go(OP_WSEC, 1'b1);
      drv.send_id(f, c);
      b = rnd();
      host(1'b1, b);
      for (int i = 0; i < 15; i++) begin
         wait_hi(1, 20000);
         chk(wr_o.data, i < 12 ? 8'h00 : (i == 12 ? 8'hf8 : (i == 13 ? b : 8'h00)));
         chk(write_gate_out_o, 1'b1);
         chk(byte_request_o, i > 12);
         chk(lost_data_o, i == 14);
         @(posedge clock_i);
         #1;
      end
      // reset in mid-sector aborts the write; a full sector outlasts the run
      @(posedge clock_i);
      reset_n_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      reset_n_i <= 1'b1;
      #1;
      chk({busy_o, write_gate_out_o, lost_data_o, head_load_out_o}, 4'h0);
      go(OP_RTRK);
      drv.pulse_index();
      fork
         drv.put(8'h4e, 1'b0);
         wait_hi(0, 200);
      join
      chk(host_data_o, 8'h4e);
      host(1'b0, 8'h00);
      chk(lost_data_o, 1'b0);
      drv.miss();
      #1;
      chk(lost_data_o, 1'b1);
      drv.pulse_index();
      wait_hi(2, 2000);
      for (int dn = 0; dn < 2; dn++) begin
         // mfm pass first, then fm
         @(posedge clock_i);
         density_select_i <= dn[0];
         go(OP_WTRK);
         chk(byte_request_o, 1'b1);
         if (dn == 0) begin
            q = '{8'hf5, 8'hf6, rnd(), 8'hf7};
         end else begin
            q = '{8'hfe, 8'hfc, rnd(), 8'hf7};
         end
         // model: expected data and clock of every slot, in order
         exq = {};
         foreach (q[k]) begin
            w = wexp(q[k], dn[0]);
            if (q[k] == 8'hf7) begin
               exq.push_back({cw[15:8], w[7:0]});
               exq.push_back({cw[7:0], w[7:0]});
            end else begin
               if (dn == 0 ? q[k] == 8'hf5 : q[k] inside {[8'hf8:8'hfb], 8'hfe}) begin
                  cw = 16'hffff;
               end
               cw = crc_b(cw, w[15:8]);
               exq.push_back(w);
            end
         end
         exq.push_back(wexp(8'h00, dn[0]));
         host(1'b1, q[0]);
         drv.pulse_index();
         // first slot launches on the edge that ends the pulse
         #1;
         for (int i = 0; i < 6; i++) begin
            wait_hi(1, 2000);
            w = exq.pop_front();
            chk(wr_o.data, w[15:8]);
            chk(wr_o.clk, w[7:0]);
            chk(write_gate_out_o, 1'b1);
            @(posedge clock_i);
            #1;
            if (i < 3) begin
               host(1'b1, q[i+1]);
            end
         end
         drv.pulse_index();
         wait_hi(2, 2000);
      end
      go(OP_WTRK);
      drv.pulse_index();
      wait_hi(3, 100);
      chk({lost_data_o, completion_irq_o}, 2'b11);
      stop_test();
   end
endmodule : tb_dst_engine
